//--- logic/sst_pkg.sv
// Purpose: constants for the startup timing command pair
// Assumes: 100 MHz core clock, timing counted in 50 us ticks
// Notes:   mantissa fields sit in the low bits of each word
package sst_pkg;
    localparam logic [7:0] CMD_DELAY    = 8'h60;
    localparam logic [7:0] CMD_RAMP     = 8'h61;
    localparam logic [4:0] EXP_FIXED    = 5'h1f;
    localparam int         EXP_LSB      = 11;
    localparam int         DLY_W        = 3;
    localparam int         RAMP_W       = 6;
    localparam logic [2:0] DLY_RST      = 3'h0;
    localparam logic [5:0] RAMP_RST     = 6'h00;
    localparam logic [6:0] DEV_ADDR     = 7'h2a;  // arbitrary bus address
    localparam int         CLK_NS       = 10;
    localparam int         TICK_NS      = 50000;  // 50 us, also the least delay
    localparam int         STEP_NS      = 500000; // 0.5 ms mantissa step
    localparam int         TICK_CYC     = TICK_NS / CLK_NS;
    localparam int         STEP_TICKS   = STEP_NS / TICK_NS;
    localparam int         CNT_W        = 9;
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_LO, ST_HI, ST_TX, ST_IGN} sst_bus_t;
    typedef enum logic [1:0] {SS_OFF, SS_DELAY, SS_RAMP, SS_ON} sst_seq_t;
endpackage

//--- logic/sst_top.sv
// Purpose: turn-on delay and soft-start ramp words behind a PMBus slave
// Assumes: scl and sda arrive raw from pins, clock 100 MHz
// Notes:   word read and write only; extra bytes after a word are refused
`timescale 1ns/10ps
module sst_top #(
    parameter int TICK_CYC = sst_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // pmbus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // restore source
    input  wire logic       nvm_restore,
    input  wire logic [1:0] nvm_delay_sel,
    input  wire logic [2:0] nvm_ramp_sel,
    input  wire logic       ramp_from_strap,
    input  wire logic [2:0] strap_ramp_sel,
    // power sequence
    input  wire logic       start_cond,
    input  wire logic       boot_from_setpoint,
    input  wire logic       setpoint_reached,
    output logic            rise_enable,
    output logic            ramp_active,
    output logic            output_in_band,
    output logic [2:0]      ramp_rate_sel,
    // status flags
    input  wire logic       flag_clear,
    output logic            cml_fault,
    output logic            invalid_data
);
    function automatic logic [8:0] dly_ticks(input logic [2:0] m);
        unique case (m)
            3'h0:    dly_ticks = 9'h001;
            3'h1:    dly_ticks = 9'(sst_pkg::STEP_TICKS);
            3'h2:    dly_ticks = 9'(2 * sst_pkg::STEP_TICKS);
            default: dly_ticks = 9'(4 * sst_pkg::STEP_TICKS);
        endcase
    endfunction

    function automatic logic [2:0] ramp_idx(input logic [5:0] m);
        if (m[5])      ramp_idx = 3'h5;
        else if (m[4]) ramp_idx = 3'h4;
        else if (m[3]) ramp_idx = 3'h3;
        else if (m[2]) ramp_idx = 3'h2;
        else if (m[1]) ramp_idx = 3'h1;
        else           ramp_idx = 3'h0;
    endfunction

    logic [2:0]        dly;
    logic [5:0]        ramp;
    logic [2:0]        scl_s;
    logic [2:0]        sda_s;
    logic [2:0]        run_s;
    sst_pkg::sst_bus_t st;
    sst_pkg::sst_seq_t ss;
    logic [3:0]        bit_cnt;
    logic              ack_ph;
    logic [7:0]        sh;
    logic [7:0]        cmd;
    logic [7:0]        lo;
    logic [7:0]        tx;
    logic              tx_hi;
    logic [15:0]       tick_cyc;
    logic [8:0]        tick_n;

    wire scl_rise = scl_s[1] & ~scl_s[2];
    wire scl_fall = ~scl_s[1] & scl_s[2];
    wire bus_start = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    wire bus_stop = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
    wire rx_done = scl_fall & (bit_cnt == 4'h8) & ~ack_ph
                 & (st inside {sst_pkg::ST_ADDR, sst_pkg::ST_CMD, sst_pkg::ST_LO,
                               sst_pkg::ST_HI});
    wire wr_hi = rx_done & (st == sst_pkg::ST_HI);
    wire [15:0] word = {sh, lo};
    wire is_dly = (cmd == sst_pkg::CMD_DELAY);
    wire ro_bad = is_dly ? (word[15:3] != {sst_pkg::EXP_FIXED, 8'h00})
                         : (word[15:6] != {sst_pkg::EXP_FIXED, 5'h00});
    wire tick = (tick_cyc == 16'(TICK_CYC - 1));
    wire start_edge = run_s[1] & ~run_s[2];
    wire [8:0] ramp_ticks = 9'(sst_pkg::STEP_TICKS) << ramp_idx(ramp);

    // pins cross in through two flops before anything looks at them
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            run_s <= 3'h0;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            run_s <= {run_s[1:0], start_cond};
        end
    end

    // byte engine: sample on scl rise, move sda only on scl fall
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st      <= sst_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            ack_ph  <= 1'b0;
            sh      <= 8'h00;
            cmd     <= 8'h00;
            lo      <= 8'h00;
            tx      <= 8'h00;
            tx_hi   <= 1'b0;
            sda_oe  <= 1'b0;
        end else if (bus_start) begin
            st      <= sst_pkg::ST_ADDR;
            bit_cnt <= 4'h0;
            ack_ph  <= 1'b0;
            sda_oe  <= 1'b0;
        end else if (bus_stop) begin
            st     <= sst_pkg::ST_IDLE;
            sda_oe <= 1'b0;
        end else if (st == sst_pkg::ST_TX) begin
            if (scl_fall && ack_ph) begin
                ack_ph  <= 1'b0;
                bit_cnt <= 4'h0;
                sda_oe  <= ~tx[7];
            end else if (scl_fall) begin
                sda_oe <= (bit_cnt < 4'h8) ? ~tx[3'(4'h7 - bit_cnt)] : 1'b0;
            // the rise inside the address ack is not the host's byte ack
            end else if (scl_rise && bit_cnt == 4'h8 && !ack_ph) begin
                // host ack after the low byte asks for the high byte
                if (!sda_s[1] && !tx_hi) begin
                    tx      <= {sst_pkg::EXP_FIXED, 3'h0};
                    tx_hi   <= 1'b1;
                    bit_cnt <= 4'h0;
                end else begin
                    st <= sst_pkg::ST_IGN;
                end
            end else if (scl_rise) begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end else if (scl_rise && bit_cnt < 4'h8) begin
            sh      <= {sh[6:0], sda_s[1]};
            bit_cnt <= bit_cnt + 4'h1;
        end else if (rx_done) begin
            ack_ph <= 1'b1;
            sda_oe <= 1'b0;
            unique case (st)
                sst_pkg::ST_ADDR: begin
                    if (sh[7:1] != sst_pkg::DEV_ADDR) begin
                        st <= sst_pkg::ST_IGN;
                    end else if (!sh[0]) begin
                        sda_oe <= 1'b1;
                        st     <= sst_pkg::ST_CMD;
                    end else if (cmd == sst_pkg::CMD_DELAY || cmd == sst_pkg::CMD_RAMP) begin
                        sda_oe <= 1'b1;
                        st     <= sst_pkg::ST_TX;
                        tx_hi  <= 1'b0;
                        tx     <= is_dly ? {5'h00, dly} : {2'h0, ramp};
                    end else begin
                        st <= sst_pkg::ST_IGN;
                    end
                end
                sst_pkg::ST_CMD: begin
                    cmd    <= sh;
                    sda_oe <= (sh == sst_pkg::CMD_DELAY || sh == sst_pkg::CMD_RAMP);
                    st     <= (sh == sst_pkg::CMD_DELAY || sh == sst_pkg::CMD_RAMP)
                              ? sst_pkg::ST_LO : sst_pkg::ST_IGN;
                end
                sst_pkg::ST_LO: begin
                    lo     <= sh;
                    sda_oe <= 1'b1;
                    st     <= sst_pkg::ST_HI;
                end
                default: begin
                    sda_oe <= ~ro_bad;
                    st     <= sst_pkg::ST_IGN;
                end
            endcase
        end else if (scl_fall && ack_ph) begin
            ack_ph  <= 1'b0;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
            // refused byte leaves the engine deaf until the next start
            if (st == sst_pkg::ST_IGN) begin
                bit_cnt <= 4'h9;
            end
        end
    end

    // the two command words; restore snaps to one canonical code per setting except ramp selects 6 and 7, which load 0
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dly  <= sst_pkg::DLY_RST;
            ramp <= sst_pkg::RAMP_RST;
        end else if (nvm_restore) begin
            dly  <= {1'b0, nvm_delay_sel};
            ramp <= 6'h01 << (ramp_from_strap ? strap_ramp_sel : nvm_ramp_sel);
        end else if (wr_hi && !ro_bad) begin
            if (is_dly) begin
                dly <= lo[2:0];
            end else begin
                ramp <= lo[5:0];
            end
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cml_fault    <= 1'b0;
            invalid_data <= 1'b0;
        end else if (wr_hi && ro_bad) begin
            cml_fault    <= 1'b1;
            invalid_data <= 1'b1;
        end else if (flag_clear) begin
            cml_fault    <= 1'b0;
            invalid_data <= 1'b0;
        end
    end

    // start sequence; settings are read live so writes take effect at once
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ss             <= sst_pkg::SS_OFF;
            tick_cyc       <= 16'h0000;
            tick_n         <= 9'h000;
            rise_enable    <= 1'b0;
            ramp_active    <= 1'b0;
            output_in_band <= 1'b0;
            ramp_rate_sel  <= 3'h0;
            sda_out        <= 1'b0;
        end else begin
            ramp_rate_sel <= ramp_idx(ramp);
            tick_cyc      <= (tick || ss == sst_pkg::SS_OFF) ? 16'h0000 : tick_cyc + 16'h0001;
            if (start_edge) begin
                ss             <= sst_pkg::SS_DELAY;
                tick_cyc       <= 16'h0000;
                tick_n         <= 9'h000;
                rise_enable    <= 1'b0;
                ramp_active    <= 1'b0;
                output_in_band <= 1'b0;
            end else if (!run_s[1]) begin
                ss             <= sst_pkg::SS_OFF;
                rise_enable    <= 1'b0;
                ramp_active    <= 1'b0;
                output_in_band <= 1'b0;
            end else if (ss == sst_pkg::SS_DELAY) begin
                if (tick_n >= dly_ticks(dly)) begin
                    ss          <= sst_pkg::SS_RAMP;
                    tick_n      <= 9'h000;
                    rise_enable <= 1'b1;
                    ramp_active <= 1'b1;
                end else if (tick) begin
                    tick_n <= tick_n + 9'h001;
                end
            end else if (ss == sst_pkg::SS_RAMP) begin
                // setpoint boot ends when the reference gets there, not by the clock
                if (boot_from_setpoint ? setpoint_reached : tick_n >= ramp_ticks) begin
                    ss             <= sst_pkg::SS_ON;
                    ramp_active    <= 1'b0;
                    output_in_band <= 1'b1;
                end else if (tick) begin
                    tick_n <= tick_n + 9'h001;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_dly;
        $rose(rise_enable) |-> $past(tick_n) >= dly_ticks($past(dly));
    endproperty
    a_dly: assert property (p_dly) else $error("output released early");
    property p_min;
        start_edge ##1 (run_s[1] && !start_edge) [*8] |-> !rise_enable;
    endproperty
    a_min: assert property (p_min) else $error("zero delay not enforced");
    property p_nack;
        wr_hi && ro_bad |=> !sda_oe && invalid_data && cml_fault;
    endproperty
    a_nack: assert property (p_nack) else $error("bad word acked");
    property p_keep;
        wr_hi && ro_bad && !nvm_restore |=> $stable(dly) && $stable(ramp);
    endproperty
    a_keep: assert property (p_keep) else $error("refused word stored");
    property p_wr;
        wr_hi && !ro_bad && is_dly && !nvm_restore |=> dly == $past(lo[2:0]) && sda_oe;
    endproperty
    a_wr: assert property (p_wr) else $error("delay not written");
    property p_set;
        wr_hi && ro_bad && flag_clear |=> invalid_data;
    endproperty
    a_set: assert property (p_set) else $error("flag set lost");
    property p_sel;
        ##1 ramp_rate_sel == ramp_idx($past(ramp));
    endproperty
    a_sel: assert property (p_sel) else $error("ramp select stale");
    property p_nvm;
        nvm_restore |=> dly[2] == 1'b0 && $onehot(ramp);
    endproperty
    a_nvm: assert property (p_nvm) else $error("restore not canonical");
    property p_restart;
        start_edge |=> ss == sst_pkg::SS_DELAY && tick_n == 9'h000 && !rise_enable;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");

    c_write: cover property (wr_hi && !ro_bad);
    c_refuse: cover property (wr_hi && ro_bad);
    c_read: cover property (st == sst_pkg::ST_TX && tx_hi);
    c_band: cover property ($rose(output_in_band));
endmodule

//--- tb/sst_host.sv
// Purpose: bus host model that runs word writes and word reads
// Assumes: sda has a pull-up, so a released line reads high
// Notes:   scl period is 8 clocks (80 ns), sda moves while scl is low except at start and stop
`timescale 1ns/10ps
module sst_host (
    // clock and wire level
    input  wire logic clk,
    input  wire logic sda_line,
    // driven pins
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic wt(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // sda moves mid-low; read late in the high half, well clear of the answer edge
    task automatic xbit(input logic b, output logic r);
        wt(2);
        sda_low = !b;
        wt(2);
        scl = 1'b1;
        wt(3);
        r = sda_line;
        wt(1);
        scl = 1'b0;
    endtask
    task automatic start();
        wt(2);
        sda_low = 1'b0;
        wt(2);
        scl = 1'b1;
        wt(4);
        sda_low = 1'b1;
        wt(4);
        scl = 1'b0;
    endtask
    task automatic stop();
        wt(2);
        sda_low = 1'b1;
        wt(2);
        scl = 1'b1;
        wt(4);
        sda_low = 1'b0;
    endtask
    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r);
        end
        xbit(1'b1, r);
        ack = !r;
    endtask
    task automatic rx(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, d[i]);
        end
        xbit(last, r);
    endtask
    // ok reflects the high byte ack only, where refusals show
    task automatic write_word(input logic [7:0] cmd, input logic [15:0] w, output logic ok);
        logic a;
        start();
        tx({sst_pkg::DEV_ADDR, 1'b0}, a);
        tx(cmd, a);
        tx(w[7:0], a);
        tx(w[15:8], ok);
        stop();
    endtask
    task automatic read_word(input logic [7:0] cmd, output logic [15:0] w);
        logic a;
        start();
        tx({sst_pkg::DEV_ADDR, 1'b0}, a);
        tx(cmd, a);
        start();
        tx({sst_pkg::DEV_ADDR, 1'b1}, a);
        rx(1'b0, w[7:0]);
        rx(1'b1, w[15:8]);
        stop();
    endtask
endmodule

//--- tb/startup_timing_config_bench.sv
// Purpose: self-checking bench for the startup timing word pair
// Assumes: tick shortened to 10 clocks, host model drives the link
// Notes:   timing windows allow for sync delay and tick phase
`timescale 1ns/10ps
module startup_timing_config_bench;
    localparam int T  = 10;
    localparam int ST = sst_pkg::STEP_TICKS;
    logic        clk, sys_rst, scl, sda_low, sda_oe, nvm_restore, ramp_from_strap;
    logic        start_cond, boot_from_setpoint, setpoint_reached, flag_clear;
    logic        rise_enable, ramp_active, output_in_band, cml_fault, invalid_data, ok, sda_out;
    logic [1:0]  nvm_delay_sel;
    logic [2:0]  nvm_ramp_sel, strap_ramp_sel, ramp_rate_sel, dm;
    logic [5:0]  rm;
    logic [15:0] rd;
    int          err_total, n_checks, n, seed;
    wire         sda_line = !(sda_low || sda_oe);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    sst_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    sst_top #(.TICK_CYC(T)) dut (
        .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .nvm_restore(nvm_restore), .nvm_delay_sel(nvm_delay_sel),
        .nvm_ramp_sel(nvm_ramp_sel), .ramp_from_strap(ramp_from_strap),
        .strap_ramp_sel(strap_ramp_sel), .start_cond(start_cond),
        .boot_from_setpoint(boot_from_setpoint), .setpoint_reached(setpoint_reached),
        .rise_enable(rise_enable), .ramp_active(ramp_active),
        .output_in_band(output_in_band), .ramp_rate_sel(ramp_rate_sel),
        .flag_clear(flag_clear), .cml_fault(cml_fault), .invalid_data(invalid_data));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: exp %h got %h", $time, exp, got);
            err_total++;
        end
    endtask
    task automatic chk_in(input int lo, input int hi, input int got);
        n_checks++;
        if (got < lo || got > hi) begin
            $display("wrong value at %0t: exp %h..%h got %h", $time, lo, hi, got);
            err_total++;
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // bounded wait: 0 for rise_enable, 1 for output_in_band
    task automatic cnt_until(input logic w, output int c);
        c = 0;
        while (((w ? output_in_band : rise_enable) !== 1'b1) && c < 9000) begin
            tick(1);
            c++;
        end
        if (c >= 9000) begin
            err_total++;
            wrap_up();
        end
    endtask
    function automatic int dly_ticks(input logic [2:0] m);
        return (m == 3'h0) ? 1 : (m < 3'h3) ? int'(m) * ST : 4 * ST;
    endfunction
    function automatic logic [2:0] ramp_idx(input logic [5:0] m);
        logic [2:0] k;
        k = 3'h0;
        for (int i = 1; i < 6; i++) begin
            if (m >= (6'h01 << i)) begin
                k = 3'(i);
            end
        end
        return k;
    endfunction
    // drop enable first so each run is a fresh start
    task automatic restart();
        start_cond = 1'b0;
        tick(6);
        start_cond = 1'b1;
        cnt_until(1'b0, n);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        wrap_up();
    end
    initial begin
        seed = 32'h04aacf61;
        {sys_rst, nvm_restore, ramp_from_strap, start_cond} = 4'h8;
        {boot_from_setpoint, setpoint_reached, flag_clear} = 3'h0;
        {nvm_delay_sel, nvm_ramp_sel, strap_ramp_sel} = 8'h00;
        tick(12);
        sys_rst = 1'b0;
        tick(4);
        host.read_word(8'h60, rd);
        chk(16'hf800, rd);
        host.read_word(8'h61, rd);
        chk(16'hf800, rd);
        for (int i = 0; i < 5; i++) begin
            dm = (i < 3) ? 3'(i) : 3'($random(seed));
            rm = (i == 1) ? 6'h3f : 6'($random(seed));
            host.write_word(8'h60, {13'h1f00, dm}, ok);
            chk({15'h0000, ok}, 16'h0001);
            host.write_word(8'h61, {10'h3e0, rm}, ok);
            chk({15'h0000, ok}, 16'h0001);
            host.read_word(8'h60, rd);
            chk({13'h1f00, dm}, rd);
            host.read_word(8'h61, rd);
            chk({10'h3e0, rm}, rd);
            chk({13'h0000, ramp_rate_sel}, {13'h0000, ramp_idx(rm)});
            restart();
            chk_in(dly_ticks(dm) * T - T, dly_ticks(dm) * T + T + 6, n);
            chk({14'h0000, ramp_active, output_in_band}, 16'h0002);
            cnt_until(1'b1, n);
            chk_in((ST << ramp_idx(rm)) * T - T, (ST << ramp_idx(rm)) * T + T + 2, n);
            chk({14'h0000, ramp_active, rise_enable}, 16'h0001);
        end
        boot_from_setpoint = 1'b1;
        restart();
        tick(5);
        setpoint_reached = 1'b1;
        cnt_until(1'b1, n);
        chk_in(0, 3, n);
        {boot_from_setpoint, setpoint_reached} = 2'h0;
        host.write_word(8'h60, 16'hf905, ok);
        chk({15'h0000, ok}, 16'h0000);
        host.read_word(8'h60, rd);
        chk({13'h1f00, dm}, rd);
        chk({14'h0000, cml_fault, invalid_data}, 16'h0003);
        flag_clear = 1'b1;
        tick(1);
        flag_clear = 1'b0;
        tick(1);
        chk({14'h0000, cml_fault, invalid_data}, 16'h0000);
        // clear held through a refused word: the set must still win
        flag_clear = 1'b1;
        host.write_word(8'h61, 16'h7801, ok);
        flag_clear = 1'b0;
        chk(16'h0000, {15'h0000, ok});
        host.write_word(8'h61, 16'h7801, ok);
        chk({15'h0000, ok}, 16'h0000);
        host.read_word(8'h61, rd);
        chk({10'h3e0, rm}, rd);
        chk({14'h0000, cml_fault, invalid_data}, 16'h0003);
        for (int s = 0; s < 4; s++) begin
            nvm_delay_sel = 2'(s);
            nvm_ramp_sel = 3'(s);
            strap_ramp_sel = 3'(5 - s);
            ramp_from_strap = s[0];
            nvm_restore = 1'b1;
            tick(1);
            nvm_restore = 1'b0;
            tick(2);
            host.read_word(8'h60, rd);
            chk({14'h3e00, 2'(s)}, rd);
            host.read_word(8'h61, rd);
            chk({10'h3e0, 6'h01 << (s[0] ? 5 - s : s)}, rd);
        end
        // unknown command: the rest of the frame is refused
        host.write_word(8'h62, 16'hf801, ok);
        chk(16'h0000, {15'h0000, ok});
        host.read_word(8'h62, rd);
        chk(16'hffff, rd);
        // reset in mid-run brings every output and both words back to reset values
        start_cond = 1'b0;
        sys_rst = 1'b1;
        tick(2);
        rd = {6'h00, sda_out, sda_oe, ramp_rate_sel, rise_enable, ramp_active, output_in_band,
              cml_fault, invalid_data};
        chk(16'h0000, rd);
        sys_rst = 1'b0;
        tick(4);
        host.read_word(8'h60, rd);
        chk(16'hf800, rd);
        host.read_word(8'h61, rd);
        chk(16'hf800, rd);
        wrap_up();
    end
endmodule
